// File: pkg/eeprom_regs.svh
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define EE_OP_READ 8'h03
`define EE_OP_WRITE 8'h02
`define EE_OP_LATCH_CLR 8'h04
`define EE_OP_LATCH_SET 8'h06
`define EE_OP_SR_READ 8'h05
`define EE_OP_SR_WRITE 8'h01

// ----------------------------------------
// Array geometry
// ----------------------------------------
`define EE_ADDR_W 14
`define EE_DEPTH 16384
`define EE_PAGE_W 6
`define EE_PAGE_BYTES 64

// ----------------------------------------
// Status register fields and reset values
// ----------------------------------------
`define EE_SR_PROTECT_PIN_EN 7
`define EE_SR_BLOCK_HIGH 3
`define EE_SR_BLOCK_LOW 2
`define EE_SR_WRITE_LATCH 1
`define EE_SR_WRITE_IN_PROGRESS 0
`define EE_SR_NV_RST 3'h0
`define EE_PIN_RST 5'h03

// ----------------------------------------
// Timing
// ----------------------------------------
`define EE_TWC_MS 5
`define EE_CLK_KHZ 40000
`define EE_WRITE_CYCLES (`EE_TWC_MS * `EE_CLK_KHZ)

`endif

// File: pkg/eeprom_pkg.sv
`default_nettype none
package eeprom_pkg;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
  } spi_pins_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_RDATA,
    ST_WDATA,
    ST_SR_READ,
    ST_SR_WRITE,
    ST_LATCH_SET,
    ST_LATCH_CLR,
    ST_IGNORE
  } frame_state_t;

endpackage
`default_nettype wire

// File: rtl/spi_serial_eeprom_access.sv
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_regs.svh"
// Functional notes
// - Chip select low selects the device; high deselects it into standby.
// - A started programming cycle completes regardless of chip select; standby follows it.
// - Serial output floats while deselected.
// - After reset no sequence is accepted until chip select has gone low.
// - Input bits captured on clock rise; output updated after clock fall.
// - Protect pin low with enable bit high refuses status writes only.
// - Protect pin falling does not disturb a running write cycle.
// - Hold falling with clock high pauses only at next clock fall; state kept.
// - Hold rising with clock high resumes only at next clock fall.
// - Chip select stays low during pause; clock and data ignored while paused.
// - Serial output floats and returns at once with hold, any clock level.
// - Eight-bit instruction register; everything travels most significant bit first.
// - Opcode 03h reads the array, 02h writes it, from the given address.
// - Opcode 06h sets the write latch, 04h clears it.
// - Opcode 05h reads status, 01h writes status.
// - Read is opcode, 16-bit address with top two bits ignored, then data out.
// - Read address advances per byte, wraps 3FFFh to 0000h, ends on deselect.
// - Latch set needs chip select rising right after eight bits.
// - Write is opcode, address, then up to 64 bytes within one page.
// - Data past a page end wraps to the start of that page.
// - Write starts only on deselect after a data bit zero; busy blocks array reads.
// - Status bit zero shows write in progress, bit one the latch; read-only.
// - Block bits protect none, 3000h-3FFFh, 2000h-3FFFh, or everything.
// - The self-timed write cycle lasts at most 5 ms.
// - Latch clears at reset and after latch clear, status write, array write.
module spi_serial_eeprom_access
  import eeprom_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `EE_WRITE_CYCLES
)(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic si_in,
  input wire logic hold_n_in,
  input wire logic wp_n_in,
  output logic so_out,
  output logic so_oe_out,
  output logic standby_out,
  output logic busy_out
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  spi_pins_t pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q, pin_lvl_d;
  logic [4:0] pin_agree;

  always_comb
  begin
    pin_agree = ~(pin_s2_q ^ pin_s3_q);
    pin_lvl_d = spi_pins_t'((pin_s2_q & pin_agree) | (pin_lvl_q & ~pin_agree));
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      pin_s1_q <= `EE_PIN_RST;
      pin_s2_q <= `EE_PIN_RST;
      pin_s3_q <= `EE_PIN_RST;
      pin_lvl_q <= `EE_PIN_RST;
    end
    else
    begin
      pin_s1_q <= spi_pins_t'({cs_n_in, sck_in, si_in, hold_n_in, wp_n_in});
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_lvl_q <= pin_lvl_d;
    end
  end

  // ----------------------------------------
  // Frame engine state
  // ----------------------------------------
  frame_state_t state_q, state_d;
  logic active_q, active_d;
  logic paused_q, paused_d;
  logic drive_q, drive_d;
  logic so_q, so_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] out_q, out_d;
  logic is_read_q, is_read_d;
  logic addr_byte_q, addr_byte_d;
  logic [5:0] addr_hi_q, addr_hi_d;
  logic [13:0] addr_q, addr_d;
  logic byte_done_q, byte_done_d;
  logic wel_q, wel_d;
  logic [2:0] sr_nv_q, sr_nv_d;
  logic [2:0] new_sr_q, new_sr_d;
  logic busy_q, busy_d;
  logic prog_sr_q, prog_sr_d;
  logic [31:0] cnt_q, cnt_d;
  logic [7:0] page_q, page_d;
  logic [5:0] poff_q, poff_d;
  logic [63:0] pval_q, pval_d;
  logic [7:0] pbuf_q [`EE_PAGE_BYTES];
  logic [7:0] pbuf_d [`EE_PAGE_BYTES];
  logic [7:0] mem [`EE_DEPTH];

  logic sck_rise, sck_fall, cs_fall, cs_rise, run;
  logic [7:0] rx, status;
  logic [13:0] next_addr, wr_addr;
  logic mem_we;
  logic page_locked;

  // Block protection is decided per page: blocks are page aligned.
  function automatic logic locked(input logic [1:0] bp, input logic [13:0] a);
    logic r;
    unique case (bp)
      2'b00: r = 1'b0;
      2'b01: r = (a[13:12] == 2'b11);
      2'b10: r = a[13];
      2'b11: r = 1'b1;
    endcase
    return r;
  endfunction

  always_comb
  begin
    state_d = state_q;
    {active_d, paused_d, drive_d, so_d, bit_d, sh_d, out_d, is_read_d} =
      {active_q, paused_q, drive_q, so_q, bit_q, sh_q, out_q, is_read_q};
    {addr_byte_d, addr_hi_d, addr_d, byte_done_d, wel_d, sr_nv_d, new_sr_d} =
      {addr_byte_q, addr_hi_q, addr_q, byte_done_q, wel_q, sr_nv_q, new_sr_q};
    {busy_d, prog_sr_d, cnt_d, page_d, poff_d, pval_d} =
      {busy_q, prog_sr_q, cnt_q, page_q, poff_q, pval_q};
    pbuf_d = pbuf_q;
    mem_we = 1'b0;
    wr_addr = {page_q, cnt_q[5:0]};
    sck_rise = ~pin_lvl_q.sck & pin_lvl_d.sck;
    sck_fall = pin_lvl_q.sck & ~pin_lvl_d.sck;
    cs_fall = pin_lvl_q.cs_n & ~pin_lvl_d.cs_n;
    cs_rise = ~pin_lvl_q.cs_n & pin_lvl_d.cs_n;
    rx = {sh_q[6:0], pin_lvl_d.si};
    next_addr = addr_q + 14'h0001;
    page_locked = locked(sr_nv_q[1:0], {page_q, 6'h00});
    status = 8'h00;
    status[`EE_SR_PROTECT_PIN_EN] = sr_nv_q[2];
    status[`EE_SR_BLOCK_HIGH] = sr_nv_q[1];
    status[`EE_SR_BLOCK_LOW] = sr_nv_q[0];
    status[`EE_SR_WRITE_LATCH] = wel_q;
    status[`EE_SR_WRITE_IN_PROGRESS] = busy_q;
    // Pause follows hold only while the clock is low, so a change made with
    // the clock high waits for the next falling clock edge.
    if (active_q && !pin_lvl_d.sck)
      paused_d = ~pin_lvl_d.hold_n;
    run = active_q & ~paused_q & ~paused_d;

    // Self-timed programming runs on its own, ignoring pins entirely.
    if (busy_q)
    begin
      cnt_d = cnt_q + 32'h1;
      mem_we = ~prog_sr_q & (cnt_q < 32'(`EE_PAGE_BYTES)) & pval_q[cnt_q[5:0]];
      if (cnt_q == 32'(WRITE_CYCLES - 1))
      begin
        busy_d = 1'b0;
        wel_d = 1'b0;
        if (prog_sr_q)
          sr_nv_d = new_sr_q;
      end
    end

    if (run && sck_rise)
    begin
      sh_d = rx;
      bit_d = bit_q + 3'h1;
      byte_done_d = 1'b0;
      if (state_q == ST_LATCH_SET || state_q == ST_LATCH_CLR)
        state_d = ST_IGNORE;
      else if (bit_q == 3'h7)
      begin
        unique case (state_q)
          ST_CMD:
          begin
            // While programming only the status read is honoured.
            state_d = ST_IGNORE;
            if (rx == `EE_OP_SR_READ)
            begin
              state_d = ST_SR_READ;
              out_d = status;
            end
            else if (!busy_q)
            begin
              unique case (rx)
                `EE_OP_READ: state_d = ST_ADDR;
                `EE_OP_WRITE: state_d = ST_ADDR;
                `EE_OP_LATCH_SET: state_d = ST_LATCH_SET;
                `EE_OP_LATCH_CLR: state_d = ST_LATCH_CLR;
                `EE_OP_SR_WRITE: state_d = ST_SR_WRITE;
                default: state_d = ST_IGNORE;
              endcase
            end
            is_read_d = (rx == `EE_OP_READ);
            addr_byte_d = 1'b0;
          end
          ST_ADDR:
          begin
            addr_byte_d = 1'b1;
            addr_hi_d = rx[5:0];
            if (addr_byte_q)
            begin
              addr_d = {addr_hi_q, rx};
              page_d = {addr_hi_q, rx[7:6]};
              poff_d = rx[5:0];
              pval_d = 64'h0;
              state_d = is_read_q ? ST_RDATA : ST_WDATA;
              out_d = mem[{addr_hi_q, rx}];
            end
          end
          ST_RDATA:
          begin
            addr_d = next_addr;
            out_d = mem[next_addr];
          end
          ST_SR_READ: out_d = status;
          ST_WDATA:
          begin
            pbuf_d[poff_q] = rx;
            pval_d[poff_q] = 1'b1;
            poff_d = poff_q + 6'h01;
            byte_done_d = 1'b1;
          end
          ST_SR_WRITE:
          begin
            new_sr_d = {rx[`EE_SR_PROTECT_PIN_EN], rx[`EE_SR_BLOCK_HIGH], rx[`EE_SR_BLOCK_LOW]};
            byte_done_d = 1'b1;
          end
          default: state_d = state_q;
        endcase
      end
    end

    if (run && sck_fall && (state_q == ST_RDATA || state_q == ST_SR_READ))
    begin
      so_d = out_q[7];
      out_d = {out_q[6:0], 1'b0};
      drive_d = 1'b1;
    end

    if (cs_rise && active_q)
    begin
      unique case (state_q)
        ST_LATCH_SET: wel_d = 1'b1;
        ST_LATCH_CLR: wel_d = 1'b0;
        ST_WDATA:
        begin
          if (byte_done_q && wel_q && !page_locked)
          begin
            busy_d = 1'b1;
            prog_sr_d = 1'b0;
            cnt_d = 32'h0;
          end
        end
        ST_SR_WRITE:
        begin
          if (byte_done_q && wel_q && !(sr_nv_q[2] && !pin_lvl_d.wp_n))
          begin
            busy_d = 1'b1;
            prog_sr_d = 1'b1;
            cnt_d = 32'h0;
          end
        end
        default: wel_d = wel_q;
      endcase
    end

    if (cs_rise)
    begin
      active_d = 1'b0;
      drive_d = 1'b0;
      paused_d = 1'b0;
      state_d = ST_IDLE;
    end
    else if (cs_fall)
    begin
      active_d = 1'b1;
      paused_d = ~pin_lvl_d.hold_n & ~pin_lvl_d.sck;
      drive_d = 1'b0;
      state_d = ST_CMD;
      bit_d = 3'h0;
      byte_done_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      state_q <= ST_IDLE;
      {active_q, paused_q, drive_q, so_q, bit_q, sh_q, out_q, is_read_q} <= '0;
      {addr_byte_q, addr_hi_q, addr_q, byte_done_q, wel_q} <= '0;
      {sr_nv_q, new_sr_q} <= {`EE_SR_NV_RST, `EE_SR_NV_RST};
      {busy_q, prog_sr_q, cnt_q, page_q, poff_q, pval_q} <= '0;
    end
    else
    begin
      state_q <= state_d;
      {active_q, paused_q, drive_q, so_q, bit_q, sh_q, out_q, is_read_q} <=
        {active_d, paused_d, drive_d, so_d, bit_d, sh_d, out_d, is_read_d};
      {addr_byte_q, addr_hi_q, addr_q, byte_done_q, wel_q, sr_nv_q, new_sr_q} <=
        {addr_byte_d, addr_hi_d, addr_d, byte_done_d, wel_d, sr_nv_d, new_sr_d};
      {busy_q, prog_sr_q, cnt_q, page_q, poff_q, pval_q} <=
        {busy_d, prog_sr_d, cnt_d, page_d, poff_d, pval_d};
    end
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Array and page buffer hold no reset: their contents are data, not control.
  always_ff @(posedge clk_sys_in)
  begin
    pbuf_q <= pbuf_d;
    if (mem_we)
      mem[wr_addr] <= pbuf_q[cnt_q[5:0]];
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Output enable tracks the synchronised hold level, not the pause state.
  assign so_out = so_q;
  assign so_oe_out = active_q & drive_q & pin_lvl_q.hold_n;
  assign standby_out = ~active_q & ~busy_q;
  assign busy_out = busy_q;

endmodule
`default_nettype wire

// File: verif/eeprom_access_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_access_monitor #(
  parameter int unsigned WRITE_CYCLES = 200
)(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic hold_n_in,
  input wire logic so_out,
  input wire logic so_oe_out,
  input wire logic standby_out,
  input wire logic busy_out
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (srst_in);
  // ----
  // Programming time counter
  // ----
  always_comb
  begin
    cnt_d = busy_out ? cnt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk_sys_in)
  begin
    cnt_q <= srst_in ? 32'h0 : cnt_d;
  end
  chk_oe_desel: assert property (cs_n_in [*6] |-> !so_oe_out)
    else $error("oe while deselected");
  chk_oe_hold: assert property (!hold_n_in [*6] |-> !so_oe_out)
    else $error("oe while held");
  chk_standby_idle: assert property ((cs_n_in && !busy_out) [*8] |-> standby_out)
    else $error("no standby");
  chk_active_sel: assert property ($fell(cs_n_in) ##1 !cs_n_in [*5] |-> !standby_out)
    else $error("standby while selected");
  chk_busy_standby: assert property (busy_out |-> !standby_out)
    else $error("standby while busy");
  chk_busy_span: assert property ($fell(busy_out) |->
    cnt_q inside {[WRITE_CYCLES - 1 : WRITE_CYCLES]})
    else $error("bad busy length");
  chk_busy_cause: assert property ($rose(busy_out) |-> cs_n_in && $past(cs_n_in, 3))
    else $error("busy without deselect");
  chk_so_edge: assert property (so_oe_out && $past(so_oe_out) && $changed(so_out)
    |-> !sck_in)
    else $error("so moved at clock high");
  chk_reset_idle: assert property (disable iff (1'b0)
    srst_in |=> !busy_out && !so_oe_out && standby_out)
    else $error("not idle after reset");
endmodule
bind spi_serial_eeprom_access eeprom_access_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_mon (
  .clk_sys_in(clk_sys_in), .srst_in(srst_in), .cs_n_in(cs_n_in), .sck_in(sck_in),
  .hold_n_in(hold_n_in), .so_out(so_out), .so_oe_out(so_oe_out),
  .standby_out(standby_out), .busy_out(busy_out)
);
`default_nettype wire

// File: verif/spi_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_master_model
  import eeprom_pkg::*;
#(
  parameter int HALF = 6
)(
  input wire logic clk_in,
  input wire logic so_in,
  input wire logic so_oe_in,
  output var spi_pins_t pins_out
);
  // The data line has no pull, so once released it shows its last level inverted.
  logic last_q;
  logic so_line;
  assign so_line = so_oe_in ? so_in : ~last_q;
  initial pins_out = 5'b00011;
  always_ff @(posedge clk_in)
  begin
    if (so_oe_in)
    begin
      last_q <= so_in;
    end
  end
  task automatic half();
    repeat (HALF) @(negedge clk_in);
  endtask
  task automatic sel(input logic v);
    pins_out.cs_n = v;
    half();
    half();
  endtask
  task automatic set_wp(input logic v);
    pins_out.wp_n = v;
    half();
  endtask
  // ----
  // Pause with the clock low; clocks sent meanwhile must be ignored.
  // ----
  task automatic pause();
    // Let the last falling clock edge land before hold drops, so its output shift is kept.
    half();
    pins_out.hold_n = 1'b0;
    half();
    repeat (3)
    begin
      pins_out.sck = 1'b1;
      pins_out.si = ~pins_out.si;
      half();
      pins_out.sck = 1'b0;
      half();
    end
    pins_out.hold_n = 1'b1;
    half();
  endtask
  task automatic xbyte(input logic [7:0] t, input int nb, input int h, output logic [7:0] r);
    r = 8'h00;
    for (int i = 7; i > 7 - nb; i--)
    begin
      if (i == h)
        pause();
      pins_out.si = t[i];
      half();
      pins_out.sck = 1'b1;
      r[i] = so_line;
      half();
      pins_out.sck = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// File: verif/spi_serial_eeprom_access_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spi_serial_eeprom_access_tb;
  import eeprom_pkg::*;
  localparam int WC = 600;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic so;
  logic so_oe;
  logic busy;
  logic standby;
  spi_pins_t pins;
  int miscompares = 0;
  int n_tests = 0;
  int seed = 32'h2890;
  int areas [3] = '{32'h1000, 32'h2040, 32'h3080};
  logic [7:0] mem [int];
  logic [2:0] nv = 3'h0;
  logic write_latch_bit = 1'b0;
  logic wp = 1'b1;
  logic [7:0] rx;
  initial
  begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  spi_serial_eeprom_access #(.WRITE_CYCLES(WC)) u_dut (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .cs_n_in(pins.cs_n), .sck_in(pins.sck),
    .si_in(pins.si), .hold_n_in(pins.hold_n), .wp_n_in(pins.wp_n), .so_out(so),
    .so_oe_out(so_oe), .standby_out(standby), .busy_out(busy)
  );
  spi_master_model u_master (.clk_in(clk_sys_in), .so_in(so), .so_oe_in(so_oe), .pins_out(pins));
  task automatic results();
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %0t byte %h not %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %0t flag %b not %b", $time, g, e);
    end
  endtask
  function automatic logic prot(input int a);
    return nv[1:0] == 2'h3 || (nv[1:0] == 2'h2 && a >= 32'h2000) ||
      (nv[1:0] == 2'h1 && a >= 32'h3000);
  endfunction
  task automatic tx(input logic [7:0] b);
    u_master.xbyte(b, 8, -1, rx);
  endtask
  task automatic cmd(input logic [7:0] op);
    u_master.sel(1'b0);
    tx(op);
    u_master.sel(1'b1);
  endtask
  task automatic wen();
    cmd(8'h06);
    write_latch_bit = 1'b1;
  endtask
  task automatic status_read_command(input logic write_in_progress_bit);
    u_master.sel(1'b0);
    tx(8'h05);
    tx(8'($random(seed)));
    chk8(rx, {nv[2], 3'h0, nv[1:0], write_latch_bit, write_in_progress_bit});
    u_master.sel(1'b1);
  endtask
  // ----
  // Programming: the protect pin falls mid-cycle, which must not matter.
  // ----
  task automatic prog(input logic ok);
    u_master.set_wp(1'b0);
    chk1(busy, ok);
    chk1(standby, !ok);
    if (ok)
    begin
      status_read_command(1'b1);
      for (int i = 0; i < 1000 && busy === 1'b1; i++)
        @(negedge clk_sys_in);
      chk1(busy, 1'b0);
      chk1(standby, 1'b1);
      write_latch_bit = 1'b0;
    end
    u_master.set_wp(wp);
  endtask
  task automatic wr(input int a, input int n, input int nb);
    logic [7:0] d;
    logic ok;
    ok = write_latch_bit && nb == 8 && !prot(a & 32'h3fc0);
    u_master.sel(1'b0);
    tx(8'h02);
    tx({2'($random(seed)), a[13:8]});
    tx(a[7:0]);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($random(seed));
      u_master.xbyte(d, (i == n - 1) ? nb : 8, -1, rx);
      if (ok)
        mem[{a[13:6], 6'(a + i)}] = d;
    end
    u_master.sel(1'b1);
    prog(ok);
  endtask
  task automatic wsr(input logic [7:0] v);
    logic ok;
    ok = write_latch_bit && !(nv[2] && !wp);
    u_master.sel(1'b0);
    tx(8'h01);
    tx(v);
    u_master.sel(1'b1);
    prog(ok);
    if (ok)
      nv = {v[7], v[3:2]};
  endtask
  task automatic rd(input int a, input int n, input int h);
    u_master.sel(1'b0);
    tx(8'h03);
    tx({2'($random(seed)), a[13:8]});
    tx(a[7:0]);
    for (int i = 0; i < n; i++)
    begin
      u_master.xbyte(8'($random(seed)), 8, (i == 1) ? h : -1, rx);
      chk8(rx, mem[(a + i) % 16384]);
    end
    u_master.sel(1'b1);
  endtask
  initial
  begin
    repeat (10) @(negedge clk_sys_in);
    srst_in = 1'b0;
    cmd(8'h06);
    status_read_command(1'b0);
    wen();
    status_read_command(1'b0);
    cmd(8'h04);
    write_latch_bit = 1'b0;
    status_read_command(1'b0);
    u_master.sel(1'b0);
    tx(8'h06);
    tx(8'h02);
    u_master.sel(1'b1);
    status_read_command(1'b0);
    wen();
    wr(32'h0, 4, 8);
    wen();
    wr(32'h3ffc, 8, 8);
    rd(32'h3ffc, 8, 4);
    rd(32'h3fc0, 4, -1);
    wen();
    wr(32'h100, 3, 4);
    status_read_command(1'b0);
    for (int bp = 0; bp < 4; bp++)
    begin
      wen();
      wsr({4'h0, 2'(bp), 2'h0});
      foreach (areas[k])
      begin
        wen();
        wr(areas[k], 2, 8);
      end
    end
    wen();
    wsr(8'h8c);
    wp = 1'b0;
    u_master.set_wp(wp);
    wen();
    wsr(8'h00);
    status_read_command(1'b0);
    wp = 1'b1;
    u_master.set_wp(wp);
    wsr(8'h00);
    wr(32'h1000, 1, 8);
    foreach (areas[k])
      rd(areas[k], 2, -1);
    results();
  end
  // About 27,000 cycles are needed; the limit leaves more than three times that.
  initial
  begin
    repeat (90000) @(posedge clk_sys_in);
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
